/* File: design/dcc_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the dma channel control top module
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// register byte addresses on the control bus
`define DCC_CTRL_OFS 8'h00
`define DCC_STAT_OFS 8'h04
`define DCC_CTRL_RST 32'h0000_0000

// control register fields
`define DCC_ABORT_BIT 27
`define DCC_PAUSE_BIT 26
`define DCC_GO_BIT 25
`define DCC_MODE_BIT 23
`define DCC_VFLUSH_BIT 17
`define DCC_PFLUSH_BIT 16
`define DCC_VME_BLOCK_SIZE_LSB 12
`define DCC_VME_BACKOFF_TIMER_LSB 8
`define DCC_PCIX_BLOCK_SIZE_LSB 4
`define DCC_PCIX_BACKOFF_TIMER_LSB 0

// status register fields
`define DCC_ST_ERR_BIT 28
`define DCC_ST_ABORT_BIT 27
`define DCC_ST_PAUSE_BIT 26
`define DCC_ST_DONE_BIT 25
`define DCC_ST_BUSY_BIT 24
`define DCC_ST_ESRC_BIT 20

// bus answers
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2

// block size of code zero, in bytes
`define DCC_BLK_MIN_BYTES 13'h0020

// back-off unit is one microsecond at a 10 ns clock
`define DCC_CLK_PERIOD_NS 10
`define DCC_BOFF_UNIT_NS 1000
`define DCC_BOFF_UNIT_CYC ((`DCC_BOFF_UNIT_NS + `DCC_CLK_PERIOD_NS - 1) / `DCC_CLK_PERIOD_NS)

`endif

/* File: design/dcc_pkg.sv */
// types shared by the dma channel control block
// needs no defines header; its numbers are written in place
package dcc_pkg;

  // channel sequencer states
  typedef enum logic [1:0] {
    DCC_ST_IDLE = 2'b00,
    DCC_ST_RUN = 2'b01,
    DCC_ST_PAUSED = 2'b10
  } dcc_state_e;

  // stored writable control fields
  typedef struct packed {
    logic mode_direct;
    logic vme_flush_on_aborted_read;
    logic pcix_flush_on_aborted_read;
    logic [2:0] vme_block_size;
    logic [2:0] vme_backoff_timer;
    logic [2:0] pcix_block_size;
    logic [2:0] pcix_backoff_timer;
  } dcc_ctrl_s;

  // one-cycle commands to the bus masters, descriptor fetcher and fifo
  typedef struct packed {
    logic start;
    logic direct;
    logic fetch_desc;
    logic stop_masters;
    logic fifo_invalidate;
    logic fifo_forward;
  } dcc_eng_cmd_s;

  // events reported back by the datapath
  typedef struct packed {
    logic xfer_done;
    logic list_last;
    logic vme_exc;
    logic pcix_exc;
    logic blk_done;
    logic blk_src_vme;
  } dcc_eng_sts_s;

endpackage

/* File: design/dcc_top.sv */
// dma channel control: axi4-lite control/status registers and channel sequencer
// assumes one clock, synchronous reset, datapath events synchronous to ref_clk
//
// What this block does
// - writing abort ends the running transaction
// - aborted transactions return to idle and can never be resumed
// - abort stops both bus masters and invalidates the fifo
// - abort clears busy and sets done and error
// - abort, pause and go act on a one and read back zero
// - pause only in linked-list mode, taking effect after current transfer
// - pause flag set when the channel actually reaches paused
// - go while paused resumes linked-list processing
// - abort wins over a pending or simultaneous pause
// - writing go starts a transaction
// - mode bit set means direct, cleared means linked-list
// - direct mode performs exactly one transfer
// - linked-list mode fetches descriptors, first from next-link address
// - vme exception forwards fifo data if vme flush set, else discards
// - pci/x exception forwards fifo data if pci/x flush set, else discards
// - vme source uses vme block size, 32 to 4096 bytes doubling
// - pci/x source uses pci/x block size, 32 to 4096 bytes doubling
// - vme back-off: zero, then one microsecond doubling to 64
// - no next vme block request until vme back-off expires
// - no next pci/x block request until pci/x back-off expires
// - go sets busy and clears completion flags; one flag on finish, done and error on abort
// - functional interrupt pulse on every busy falling edge
`include "dcc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dcc_top #(
  parameter int ADDR_W = 8,
  parameter int US_CYCLES = `DCC_BOFF_UNIT_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dcc_pkg::dcc_eng_sts_s eng_sts,
  output dcc_pkg::dcc_eng_cmd_s eng_cmd,
  output logic blk_req,
  output logic [12:0] blk_bytes,
  output logic func_irq
);
  import dcc_pkg::*;

  // word indexes of the two registers, as wide as the address above the byte bits
  localparam logic [ADDR_W-3:0] CTRL_IDX = (ADDR_W-2)'(`DCC_CTRL_OFS >> 2);
  localparam logic [ADDR_W-3:0] STAT_IDX = (ADDR_W-2)'(`DCC_STAT_OFS >> 2);

  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_word;
  logic do_write, wr_ctrl, cmd_go, cmd_pause, cmd_abort;
  dcc_ctrl_s ctrl_r;
  dcc_state_e st_r;
  logic busy_flag_r, done_flag_r, pause_flag_r, abort_flag_r, err_flag_r, err_src_r;
  logic direct_r, pause_pend_r, busy_d_r;
  logic err_now, abort_now, flush_sel, pause_now, list_end, next_desc, mode_now;
  dcc_eng_cmd_s eng_cmd_r;
  logic [2:0] boff_code;
  logic [6:0] boff_us_r;
  logic [15:0] tick_r;
  logic boff_wait_r, blk_req_r;
  logic [12:0] blk_bytes_r;
  logic func_irq_r;

  // wait in microseconds for a back-off code: zero, then 1 doubling to 64
  function automatic logic [6:0] boff_us(input logic [2:0] code);
    logic [6:0] v;
    v = 7'h00;
    if (code != 3'h0)
    begin
      v = 7'h01 << (code - 3'h1);
    end
    return v;
  endfunction

  // write channel holding flags, released once the response is taken
  assign aw_have_nxt = (aw_have_r | (s_axi_awvalid & awready_r)) & ~(bvalid_r & s_axi_bready);
  assign w_have_nxt = (w_have_r | (s_axi_wvalid & wready_r)) & ~(bvalid_r & s_axi_bready);
  assign do_write = aw_have_r & w_have_r & ~bvalid_r;
  assign wr_ctrl = do_write & (awaddr_r[ADDR_W-1:2] == CTRL_IDX);

  // commands act only on a written one in the top byte lane
  assign cmd_go = wr_ctrl & wstrb_r[3] & wdata_r[`DCC_GO_BIT];
  assign cmd_pause = wr_ctrl & wstrb_r[3] & wdata_r[`DCC_PAUSE_BIT];
  assign cmd_abort = wr_ctrl & wstrb_r[3] & wdata_r[`DCC_ABORT_BIT];

  // address and data capture, in either order
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= ~aw_have_nxt;
      wready_r <= ~w_have_nxt;
      if (s_axi_awvalid && awready_r)
      begin
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // write response; status is read-only, unmapped addresses get slverr
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `DCC_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      if (awaddr_r[ADDR_W-1:2] == CTRL_IDX ||
          awaddr_r[ADDR_W-1:2] == STAT_IDX)
      begin
        bresp_r <= `DCC_RESP_OKAY;
      end
      else
      begin
        bresp_r <= `DCC_RESP_SLVERR;
      end
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // writable fields, byte-lane gated, zero after reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_r <= dcc_ctrl_s'(`DCC_CTRL_RST);
    end
    else if (wr_ctrl)
    begin
      if (wstrb_r[0])
      begin
        ctrl_r.pcix_block_size <= wdata_r[`DCC_PCIX_BLOCK_SIZE_LSB +: 3];
        ctrl_r.pcix_backoff_timer <= wdata_r[`DCC_PCIX_BACKOFF_TIMER_LSB +: 3];
      end
      if (wstrb_r[1])
      begin
        ctrl_r.vme_block_size <= wdata_r[`DCC_VME_BLOCK_SIZE_LSB +: 3];
        ctrl_r.vme_backoff_timer <= wdata_r[`DCC_VME_BACKOFF_TIMER_LSB +: 3];
      end
      if (wstrb_r[2])
      begin
        ctrl_r.mode_direct <= wdata_r[`DCC_MODE_BIT];
        ctrl_r.vme_flush_on_aborted_read <= wdata_r[`DCC_VFLUSH_BIT];
        ctrl_r.pcix_flush_on_aborted_read <= wdata_r[`DCC_PFLUSH_BIT];
      end
    end
  end

  // read word assembly; command bits and reserved bits read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr[ADDR_W-1:2] == CTRL_IDX)
    begin
      rd_word[`DCC_MODE_BIT] = ctrl_r.mode_direct;
      rd_word[`DCC_VFLUSH_BIT] = ctrl_r.vme_flush_on_aborted_read;
      rd_word[`DCC_PFLUSH_BIT] = ctrl_r.pcix_flush_on_aborted_read;
      rd_word[`DCC_VME_BLOCK_SIZE_LSB +: 3] = ctrl_r.vme_block_size;
      rd_word[`DCC_VME_BACKOFF_TIMER_LSB +: 3] = ctrl_r.vme_backoff_timer;
      rd_word[`DCC_PCIX_BLOCK_SIZE_LSB +: 3] = ctrl_r.pcix_block_size;
      rd_word[`DCC_PCIX_BACKOFF_TIMER_LSB +: 3] = ctrl_r.pcix_backoff_timer;
    end
    else if (s_axi_araddr[ADDR_W-1:2] == STAT_IDX)
    begin
      rd_word[`DCC_ST_ERR_BIT] = err_flag_r;
      rd_word[`DCC_ST_ABORT_BIT] = abort_flag_r;
      rd_word[`DCC_ST_PAUSE_BIT] = pause_flag_r;
      rd_word[`DCC_ST_DONE_BIT] = done_flag_r;
      rd_word[`DCC_ST_BUSY_BIT] = busy_flag_r;
      rd_word[`DCC_ST_ESRC_BIT] = err_src_r;
    end
  end

  // read channel: one read at a time, answer one cycle after address
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `DCC_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      if (s_axi_araddr[ADDR_W-1:2] == CTRL_IDX ||
          s_axi_araddr[ADDR_W-1:2] == STAT_IDX)
      begin
        rresp_r <= `DCC_RESP_OKAY;
      end
      else
      begin
        rresp_r <= `DCC_RESP_SLVERR;
      end
    end
    else if (!rvalid_r || s_axi_rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // a mode bit written in the same word as go governs that go
  assign mode_now = (wr_ctrl & wstrb_r[2]) ? wdata_r[`DCC_MODE_BIT] : ctrl_r.mode_direct;

  // event decode; an exception outranks an abort seen in the same cycle
  assign err_now = (st_r == DCC_ST_RUN) & (eng_sts.vme_exc | eng_sts.pcix_exc);
  // abort taken ahead of any pause
  assign abort_now = cmd_abort & (st_r != DCC_ST_IDLE) & ~err_now;
  assign flush_sel = eng_sts.vme_exc ? ctrl_r.vme_flush_on_aborted_read : ctrl_r.pcix_flush_on_aborted_read;
  assign list_end = eng_sts.xfer_done & (direct_r | eng_sts.list_last);
  // pause lands only at a linked-list transfer boundary
  assign pause_now = eng_sts.xfer_done & ~list_end & (pause_pend_r | (cmd_pause & ~direct_r));
  assign next_desc = (st_r == DCC_ST_RUN) & ~err_now & ~abort_now & eng_sts.xfer_done & ~list_end & ~pause_now;

  // channel sequencer and completion flags
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r <= DCC_ST_IDLE;
      busy_flag_r <= 1'b0;
      done_flag_r <= 1'b0;
      pause_flag_r <= 1'b0;
      abort_flag_r <= 1'b0;
      err_flag_r <= 1'b0;
      err_src_r <= 1'b0;
      direct_r <= 1'b0;
      pause_pend_r <= 1'b0;
    end
    else if (err_now)
    begin
      st_r <= DCC_ST_IDLE;
      busy_flag_r <= 1'b0;
      err_flag_r <= 1'b1;
      err_src_r <= ~eng_sts.vme_exc;
      pause_pend_r <= 1'b0;
    end
    else if (abort_now)
    begin
      // transaction dropped for good, done and error raised
      st_r <= DCC_ST_IDLE;
      busy_flag_r <= 1'b0;
      done_flag_r <= 1'b1;
      err_flag_r <= 1'b1;
      pause_flag_r <= 1'b0;
      pause_pend_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        DCC_ST_IDLE:
        begin
          // start, latch mode, clear completion flags
          if (cmd_go)
          begin
            st_r <= DCC_ST_RUN;
            busy_flag_r <= 1'b1;
            done_flag_r <= 1'b0;
            pause_flag_r <= 1'b0;
            abort_flag_r <= 1'b0;
            err_flag_r <= 1'b0;
            err_src_r <= 1'b0;
            direct_r <= mode_now;
            pause_pend_r <= 1'b0;
          end
        end
        DCC_ST_RUN:
        begin
          // go ignored here; pause held until boundary
          if (list_end)
          begin
            st_r <= DCC_ST_IDLE;
            busy_flag_r <= 1'b0;
            done_flag_r <= 1'b1;
            pause_pend_r <= 1'b0;
          end
          else if (pause_now)
          begin
            st_r <= DCC_ST_PAUSED;
            busy_flag_r <= 1'b0;
            pause_flag_r <= 1'b1;
            pause_pend_r <= 1'b0;
          end
          else if (cmd_pause && !direct_r)
          begin
            pause_pend_r <= 1'b1;
          end
        end
        DCC_ST_PAUSED:
        begin
          if (cmd_go)
          begin
            st_r <= DCC_ST_RUN;
            busy_flag_r <= 1'b1;
            pause_flag_r <= 1'b0;
          end
        end
        default:
        begin
          st_r <= DCC_ST_IDLE;
        end
      endcase
    end
  end

  // one-cycle commands to the datapath
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      eng_cmd_r <= '0;
    end
    else
    begin
      eng_cmd_r.start <= (st_r == DCC_ST_IDLE) & cmd_go;
      eng_cmd_r.direct <= (st_r == DCC_ST_IDLE) ? mode_now : direct_r;
      // first fetch from next-link address, then one per finished non-final transfer, at once or on resume
      eng_cmd_r.fetch_desc <= ((st_r == DCC_ST_IDLE) & cmd_go & ~mode_now) |
                              ((st_r == DCC_ST_PAUSED) & cmd_go & ~cmd_abort) | next_desc;
      eng_cmd_r.stop_masters <= abort_now;
      // fifo discarded on abort, or on exception without flush
      eng_cmd_r.fifo_invalidate <= abort_now | (err_now & ~flush_sel);
      eng_cmd_r.fifo_forward <= err_now & flush_sel;
    end
  end

  // back-off code and block size of the current source
  assign boff_code = eng_sts.blk_src_vme ? ctrl_r.vme_backoff_timer : ctrl_r.pcix_backoff_timer;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      blk_bytes_r <= `DCC_BLK_MIN_BYTES;
    end
    else if (eng_sts.blk_src_vme)
    begin
      blk_bytes_r <= `DCC_BLK_MIN_BYTES << ctrl_r.vme_block_size;
    end
    else
    begin
      blk_bytes_r <= `DCC_BLK_MIN_BYTES << ctrl_r.pcix_block_size;
    end
  end

  // back-off wait between a finished block and the next request
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || st_r != DCC_ST_RUN || err_now || abort_now)
    begin
      boff_wait_r <= 1'b0;
      boff_us_r <= 7'h00;
      tick_r <= 16'h0000;
      blk_req_r <= 1'b0;
    end
    else if (eng_sts.blk_done)
    begin
      boff_wait_r <= 1'b1;
      boff_us_r <= boff_us(boff_code);
      tick_r <= 16'h0000;
      blk_req_r <= 1'b0;
    end
    else if (boff_wait_r && boff_us_r == 7'h00)
    begin
      boff_wait_r <= 1'b0;
      blk_req_r <= 1'b1;
    end
    else
    begin
      blk_req_r <= 1'b0;
      if (boff_wait_r)
      begin
        if (tick_r == 16'(US_CYCLES - 1))
        begin
          tick_r <= 16'h0000;
          boff_us_r <= boff_us_r - 7'h01;
        end
        else
        begin
          tick_r <= tick_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy_d_r <= 1'b0;
      func_irq_r <= 1'b0;
    end
    else
    begin
      busy_d_r <= busy_flag_r;
      func_irq_r <= busy_d_r & ~busy_flag_r;
    end
  end

  // output ports, all from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign eng_cmd = eng_cmd_r;
  assign blk_req = blk_req_r;
  assign blk_bytes = blk_bytes_r;
  assign func_irq = func_irq_r;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_abort_end;
    abort_now |=> !busy_flag_r && done_flag_r && err_flag_r && st_r == DCC_ST_IDLE;
  endproperty
  a_abort_end: assert property (p_abort_end) else $error("abort did not end the transaction");

  property p_abort_stop;
    abort_now |=> eng_cmd_r.stop_masters && eng_cmd_r.fifo_invalidate && !eng_cmd_r.fifo_forward;
  endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("abort did not stop masters and fifo");

  property p_no_resume;
    abort_now ##1 (!cmd_go)[*2] |-> st_r != DCC_ST_PAUSED && !busy_flag_r;
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("aborted transaction came back");

  property p_cmd_zero;
    s_axi_arvalid && arready_r && s_axi_araddr[ADDR_W-1:2] == CTRL_IDX
      |=> s_axi_rdata[`DCC_ABORT_BIT:`DCC_GO_BIT] == 3'h0;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command bits read back nonzero");

  property p_pause_ll;
    st_r == DCC_ST_RUN && direct_r |=> st_r != DCC_ST_PAUSED;
  endproperty
  a_pause_ll: assert property (p_pause_ll) else $error("direct transaction paused");

  property p_pause_flag;
    st_r == DCC_ST_PAUSED |-> pause_flag_r && !busy_flag_r;
  endproperty
  a_pause_flag: assert property (p_pause_flag) else $error("paused without pause flag");

  property p_resume;
    st_r == DCC_ST_PAUSED && cmd_go && !cmd_abort |=> st_r == DCC_ST_RUN && busy_flag_r && eng_cmd_r.fetch_desc;
  endproperty
  a_resume: assert property (p_resume) else $error("go did not resume the list");

  property p_go_start;
    st_r == DCC_ST_IDLE && cmd_go |=> busy_flag_r && !done_flag_r && !err_flag_r && eng_cmd_r.start;
  endproperty
  a_go_start: assert property (p_go_start) else $error("go did not start");

  property p_go_ignored;
    st_r == DCC_ST_RUN && cmd_go |=> !eng_cmd_r.start;
  endproperty
  a_go_ignored: assert property (p_go_ignored) else $error("go restarted a running channel");

  property p_flush;
    err_now |=> eng_cmd_r.fifo_forward == $past(flush_sel) && eng_cmd_r.fifo_invalidate != $past(flush_sel);
  endproperty
  a_flush: assert property (p_flush) else $error("exception flush choice wrong");

  property p_backoff;
    eng_sts.blk_done && st_r == DCC_ST_RUN && boff_code != 3'h0 && !err_now && !abort_now
      |=> !blk_req_r [*2];
  endproperty
  a_backoff: assert property (p_backoff) else $error("block requested before back-off");

  property p_irq;
    $fell(busy_flag_r) |=> func_irq_r;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt on busy fall");

endmodule

`default_nettype wire

/* File: test/dcc_eng_model.sv */
// datapath model: descriptor fetch, transfers and bus events behind the channel
// assumes eng_cmd pulses from dcc_top and event requests from the bench
`timescale 1ns/1ps
`default_nettype none
module dcc_eng_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire dcc_pkg::dcc_eng_cmd_s eng_cmd,
  input wire logic [3:0] n_desc,
  input wire logic [2:0] ev,
  input wire logic src_vme,
  output dcc_pkg::dcc_eng_sts_s eng_sts
);
  import dcc_pkg::*;
  logic [4:0] dly_r;
  logic [3:0] cnt_r;
  // each transfer takes 20 cycles; stopped masters drop it
  // one transfer per start or fetch
  always_ff @(posedge ref_clk)
  begin
    eng_sts <= '0;
    eng_sts.blk_done <= ev[2];
    eng_sts.vme_exc <= ev[1];
    eng_sts.pcix_exc <= ev[0];
    eng_sts.blk_src_vme <= src_vme;
    if (sys_rst || eng_cmd.stop_masters)
      dly_r <= 5'h00;
    else if (eng_cmd.fetch_desc || eng_cmd.start)
      dly_r <= 5'h14;
    else if (dly_r != 5'h00)
      dly_r <= dly_r - 5'h01;
    if (sys_rst || eng_cmd.start)
      cnt_r <= 4'h0;
    if (dly_r == 5'h01)
    begin
      eng_sts.xfer_done <= 1'b1;
      eng_sts.list_last <= eng_cmd.direct || (cnt_r + 4'h1 >= n_desc);
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: test/test_dma_channel_control.sv */
// self-checking bench for the dma channel control block
// assumes dcc_top with a 2-cycle microsecond and the datapath model
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_control;
  import dcc_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'h0, n_desc = 4'h3;
  logic [2:0] ev = 3'h0;
  logic src_vme = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, blk_req, func_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] blk_bytes;
  dcc_eng_cmd_s eng_cmd;
  dcc_eng_sts_s eng_sts;
  logic [33:0] exp_q[$];
  int n_errors = 0, cmp_count = 0, n_fetch = 0, n_xfer = 0, n_inv = 0, n_fwd = 0, n_start = 0, n_stop = 0;
  int k, b, c, s0, s1, s2;

  dcc_top #(.US_CYCLES(2)) u_dcc_top (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .eng_sts, .eng_cmd, .blk_req, .blk_bytes, .func_irq);
  dcc_eng_model u_dcc_eng_model (.ref_clk, .sys_rst, .eng_cmd, .n_desc, .ev, .src_vme, .eng_sts);

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check("bresp", s_axi_bresp, er);
  endtask

  // read: the expected answer is noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_q.push_back({er, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
  endtask

  task automatic fin;
    do @(posedge ref_clk); while (!func_irq);
  endtask

  task automatic pulse(input logic [2:0] e);
    ev <= e;
    @(posedge ref_clk);
    ev <= 3'h0;
  endtask

  // monitor: each read answer against the oldest note
  always @(posedge ref_clk)
    if (s_axi_rvalid && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

  // tally command pulses and finished transfers
  always @(posedge ref_clk)
  begin
    n_fetch += eng_cmd.fetch_desc;
    n_start += eng_cmd.start;
    n_stop += eng_cmd.stop_masters;
    n_inv += eng_cmd.fifo_invalidate;
    n_fwd += eng_cmd.fifo_forward;
    n_xfer += eng_sts.xfer_done;
  end

  // watchdog
  initial
  begin
    #100000;
    n_errors++;
    results;
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h4f1dd8c4));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check("blk_bytes", blk_bytes, 13'h0020);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    r = $urandom;
    wr(8'h00, r, 4'h7, 2'h0);
    rd(8'h00, r & 32'h0083_7777, 2'h0);
    wr(8'h10, 32'hFFFF_FFFF, 4'hF, 2'h2);
    rd(8'h10, 32'h0, 2'h2);
    // direct mode, pause ignored there
    n_desc <= 4'hF;
    b = n_xfer;
    wr(8'h00, 32'h0280_0000, 4'hF, 2'h0);
    rd(8'h00, 32'h0080_0000, 2'h0);
    rd(8'h04, 32'h0100_0000, 2'h0);
    check("direct", eng_cmd.direct, 1'b1);
    wr(8'h00, 32'h0400_0000, 4'h8, 2'h0);
    fin;
    check("xfers", n_xfer - b, 1);
    rd(8'h04, 32'h0200_0000, 2'h0);
    // linked list paused after one transfer, then resumed
    n_desc <= 4'h3;
    b = n_fetch;
    k = n_xfer;
    wr(8'h00, 32'h0200_0000, 4'hF, 2'h0);
    check("direct", eng_cmd.direct, 1'b0);
    wr(8'h00, 32'h0400_0000, 4'h8, 2'h0);
    fin;
    rd(8'h04, 32'h0400_0000, 2'h0);
    check("paused xfers", n_xfer - k, 1);
    wr(8'h00, 32'h0200_0000, 4'h8, 2'h0);
    fin;
    rd(8'h04, 32'h0200_0000, 2'h0);
    check("fetches", n_fetch - b, 3);
    // exceptions on each bus, flush set and clear
    for (int j = 0; j < 4; j++)
    begin
      src_vme <= j[1];
      k = n_fwd;
      b = n_inv;
      wr(8'h00, 32'h0200_0000 | (32'(j[0]) << (j[1] ? 17 : 16)), 4'hF, 2'h0);
      pulse(j[1] ? 3'h2 : 3'h1);
      fin;
      check("forward", n_fwd - k, j[0]);
      check("discard", n_inv - b, !j[0]);
      rd(8'h04, {3'h0, 1'b1, 7'h00, !j[1], 20'h00000}, 2'h0);
    end
    // block size and back-off per source, then abort with pause
    n_desc <= 4'hF;
    s0 = n_stop;
    s1 = n_inv;
    s2 = n_start;
    for (int i = 0; i < 8; i++)
    begin
      src_vme <= i[0];
      c = i[0] ? i : i ^ 4;
      r = 32'(i) * 32'h0000_1100 + 32'(i ^ 4) * 32'h0000_0011;
      wr(8'h00, r | 32'h0200_0000, 4'hF, 2'h0);
      wr(8'h00, 32'h0200_0000, 4'h8, 2'h0);
      pulse(3'h4);
      do @(posedge ref_clk); while (!eng_sts.blk_done);
      k = 0;
      do
      begin
        @(posedge ref_clk);
        k++;
      end while (!blk_req);
      check("backoff", k, c == 0 ? 2 : (1 << c) + 2);
      check("blk_bytes", blk_bytes, 13'h0020 << c);
      wr(8'h00, 32'h0C00_0000, 4'h8, 2'h0);
      fin;
      rd(8'h04, 32'h1200_0000, 2'h0);
    end
    check("stops", n_stop - s0, 8);
    check("invalidates", n_inv - s1, 8);
    check("starts", n_start - s2, 8);
    b = n_fetch;
    repeat (40) @(posedge ref_clk);
    check("no resume", n_fetch - b, 0);
    results;
  end
endmodule
`default_nettype wire
